// ===== include/tic_pkg.sv
/*
 Constants, types and header-word helpers for the tape Initialize command
 and message packet builder. Assumes a 32-bit APB with byte addresses.
*/
`default_nettype none
package tic_pkg;
    localparam int ADDR_W = 8;
    localparam int MSG_WORDS = 6;
    localparam logic [7:0] A_CMD0 = 8'h00;
    localparam logic [7:0] A_CMD1 = 8'h04;
    localparam logic [7:0] A_CTRL = 8'h08;
    localparam logic [7:0] A_SSR = 8'h0c;
    localparam logic [7:0] A_RESID = 8'h10;
    localparam logic [7:0] A_EXTENDED_STATUS_WORD_ZERO = 8'h14;
    localparam logic [7:0] A_EXTENDED_STATUS_WORD_THREE = 8'h20;
    localparam logic [7:0] A_MREQ = 8'h24;
    localparam logic [7:0] A_MSG0 = 8'h28;
    localparam logic [7:0] A_MSG5 = 8'h3c;
    localparam logic [7:0] A_IRQ_ST = 8'h40;
    localparam logic [7:0] A_IRQ_CLR = 8'h44;
    localparam logic [7:0] A_IRQ_EN = 8'h48;
    localparam logic [7:0] A_RETAIN = 8'h4c;
    localparam logic [3:0] CMD_INIT = 4'hb;
    localparam int CMD_IE_BIT = 7;
    localparam int CMD_MODE_LSB = 8;
    localparam logic [15:0] CMD_MODE_MASK = 16'h0f00;
    localparam int HDR_ACK_BIT = 15;
    localparam logic [2:0] HDR_RSV = 3'h0;
    localparam logic [3:0] CLS_ATTENTION_MESSAGE = 4'h0;
    localparam logic [3:0] CLS_OTHER = 4'h1;
    localparam logic [3:0] CLS_WLE_NEF = 4'h2;
    localparam logic [2:0] FMT_ONE_WORD = 3'h0;
    localparam logic [4:0] MC_END = 5'h10;
    localparam logic [4:0] MC_FAIL = 5'h11;
    localparam logic [4:0] MC_ERROR = 5'h12;
    localparam logic [4:0] MC_ATTENTION_MESSAGE = 5'h13;
    localparam logic [2:0] TC_END = 3'h0;
    localparam logic [2:0] TC_ATTENTION_MESSAGE = 3'h1;
    localparam logic [2:0] TC_FAIL = 3'h3;
    localparam logic [15:0] EXTENDED_STATUS_WORD_THREE_KEEP = 16'hff02;
    localparam int IRQ_MSG = 0;
    localparam int IRQ_INIT = 1;
    localparam int IRQ_REJ = 2;
    localparam int MREQ_KIND_BIT = 4;
    localparam int SSR_DIAG_BIT = 4;
    localparam int SSR_READY_BIT = 7;

    typedef enum logic [1:0] {ST_IDLE, ST_BUILD, ST_INIT} tic_state_type;

    function automatic logic [4:0] msg_code(input logic [2:0] tc);
        case (tc)
            3'h0, 3'h2: msg_code = MC_END; // see R10
            3'h3: msg_code = MC_FAIL;
            3'h1: msg_code = MC_ATTENTION_MESSAGE;
            default: msg_code = MC_ERROR;
        endcase
    endfunction

    function automatic logic is_end(input logic [2:0] tc);
        is_end = (msg_code(tc) == MC_END);
    endfunction

    // Kind selects the write-lock / nonexecutable class on a failure
    function automatic logic [15:0] hdr_word(input logic [2:0] tc, input logic kind);
        logic [3:0] cls;
        cls = CLS_ATTENTION_MESSAGE;
        if (tc == TC_FAIL) begin
            cls = kind ? CLS_WLE_NEF : CLS_OTHER; // see R8
        end
        hdr_word = {tc != TC_ATTENTION_MESSAGE, HDR_RSV, cls, FMT_ONE_WORD, msg_code(tc)}; // see R5 R6 R7 R9
    endfunction
endpackage
`default_nettype wire

// ===== include/tic_msg_if.sv
/*
 Port bundle between the message builder and its packet word store.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/100ps
`default_nettype none
interface tic_msg_if #(parameter int AW = 3, parameter int DW = 16);
    logic we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    modport builder (output we, waddr, wdata, raddr, input rdata);
    modport store (input we, waddr, wdata, raddr, output rdata);
endinterface
`default_nettype wire

// ===== hdl/tic_msg_store.sv
/*
 Small word store holding the last message packet; read data is registered.
 Assumes the builder never addresses beyond the packet length.
*/
`timescale 1ns/100ps
`default_nettype none
module tic_msg_store #(
    parameter int WORDS = 6,
    parameter int DW = 16
) (
    input wire logic pclk,
    tic_msg_if.store m
);
    import tic_pkg::*;
    logic [DW-1:0] mem [WORDS];
    initial begin
        if (WORDS < 1 || WORDS > (1 << $bits(m.raddr)) || DW != $bits(m.wdata)) begin
            $error("tic_msg_store: parameters do not fit the port bundle");
        end
    end
    always_ff @(posedge pclk) begin
        if (m.we) begin
            mem[m.waddr] <= m.wdata;
        end
        m.rdata <= mem[m.raddr];
    end
endmodule
`default_nettype wire

// ===== hdl/tic_core.sv
/*
 APB-reached Initialize command interpreter and message packet builder.
 Assumes command words and status come from software or sibling logic
 over APB; messages are read back from the word store.
*/
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// (R1) Initialize without pending diagnostic errors only refreshes the message, like Get Status.
// (R2) Initialize with pending diagnostic errors acts as a subsystem status write.
// (R3) Initialize mode field must be zero; it reads back as zero.
// (R4) Second command word is taken but ignored and reads as zero.
// (R5) Header bit 15 tells the host the command buffer is free.
// (R6) Attention messages leave the command-buffer-free bit clear.
// (R7) Header bits 14 to 12 are always zero.
// (R8) Header bits 11 to 8 carry the class: attention, other failure, write-lock.
// (R9) Header bits 7 to 5 are always 000, a one-word header.
// (R10) Header bits 4 to 0 encode end, fail, error or attention from the tc value.
// (R11) Packet order: header, residual count, extended status words zero to three.
// (R12) A word write to the status register halts work and erases retained state.
// (R13) Extended status error bits clear once an end message is delivered.
// (R14) Initialize header carries code 1011, format 000, interrupt enable bit 7.
module tic_core #(
    parameter int WORDS = tic_pkg::MSG_WORDS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tic_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    import tic_pkg::*;

    typedef struct packed {
        tic_state_type state;
        logic [15:0] cmd0;
        logic diag;
        logic [15:0] resid;
        logic [3:0][15:0] xst;
        logic [1:0] retain;
        logic [2:0] tc;
        logic kind;
        logic ie;
        logic [2:0] idx;
        logic [2:0] irq_st;
        logic [2:0] irq_en;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic slow_rd;
        logic irq;
    } tic_regs_type;

    tic_regs_type q;
    tic_regs_type next_q;
    tic_msg_if #(.AW(3), .DW(16)) m ();

    initial begin
        if (WORDS != MSG_WORDS) begin
            $error("tic_core: packet length is fixed at six words");
        end
    end

    function automatic logic [15:0] msg_word(input tic_regs_type r, input logic [2:0] i);
        case (i)
            3'h0: msg_word = hdr_word(r.tc, r.kind);
            3'h1: msg_word = r.resid;
            3'h2: msg_word = r.xst[0];
            3'h3: msg_word = r.xst[1];
            3'h4: msg_word = r.xst[2];
            default: msg_word = r.xst[3];
        endcase
    endfunction

    logic setup;
    logic is_msg;
    logic wr;
    logic busy_wr;
    logic go_ok;
    logic ssr_word;
    logic hit;
    logic [15:0] rd_val;
    logic [2:0] irq_set;
    logic [15:0] cmd_view;

    assign setup = psel & ~penable;
    assign is_msg = ~pwrite & (paddr >= A_MSG0) & (paddr <= A_MSG5);
    assign wr = psel & penable & q.pready & ~q.pslverr & pwrite;
    assign busy_wr = (q.state != ST_IDLE) & pwrite
                     & (((paddr == A_CTRL) & pwdata[0]) | (paddr == A_MREQ));
    assign go_ok = wr & (paddr == A_CTRL) & pwdata[0];
    assign ssr_word = wr & (paddr == A_SSR) & (pstrb == 4'hf);
    // Mode bits of an Initialize are never shown, even if set (see R3)
    assign cmd_view = (q.cmd0[3:0] == CMD_INIT) ? (q.cmd0 & ~CMD_MODE_MASK) : q.cmd0;
    assign m.raddr = 3'((paddr - A_MSG0) >> 2);
    assign m.we = (q.state == ST_BUILD);
    assign m.waddr = q.idx;
    assign m.wdata = msg_word(q, q.idx); // see R11

    always_comb begin
        hit = 1'b1;
        rd_val = 16'h0;
        case (paddr)
            A_CMD0: rd_val = cmd_view;
            A_CMD1: rd_val = 16'h0; // see R4
            A_CTRL: rd_val = {15'h0, q.diag};
            A_SSR: rd_val = {8'h0, q.state == ST_IDLE, 2'h0, q.diag, q.tc,
                             q.state != ST_IDLE};
            A_RESID: rd_val = q.resid;
            A_EXTENDED_STATUS_WORD_ZERO: rd_val = q.xst[0];
            A_EXTENDED_STATUS_WORD_ZERO + 8'h04: rd_val = q.xst[1];
            A_EXTENDED_STATUS_WORD_ZERO + 8'h08: rd_val = q.xst[2];
            A_EXTENDED_STATUS_WORD_THREE: rd_val = q.xst[3];
            A_MREQ: rd_val = {11'h0, q.kind, 1'b0, q.tc};
            A_IRQ_ST: rd_val = {13'h0, q.irq_st};
            A_IRQ_CLR: rd_val = 16'h0;
            A_IRQ_EN: rd_val = {13'h0, q.irq_en};
            A_RETAIN: rd_val = {14'h0, q.retain};
            default: hit = is_msg;
        endcase
    end

    always_comb begin
        next_q = q;
        irq_set = 3'h0;
        next_q.pready = 1'b0;
        next_q.pslverr = 1'b0;
        next_q.slow_rd = 1'b0;
        // Store reads cost one wait state since its data is registered
        if (setup) begin
            if (is_msg) begin
                next_q.slow_rd = 1'b1;
            end else begin
                next_q.pready = 1'b1;
                next_q.pslverr = ~hit | busy_wr;
                next_q.prdata = pwrite ? 32'h0 : {16'h0, rd_val};
            end
        end
        if (q.slow_rd) begin
            next_q.pready = 1'b1;
            next_q.prdata = {16'h0, m.rdata};
        end
        case (q.state)
            ST_BUILD: begin
                if (q.idx == 3'(MSG_WORDS - 1)) begin
                    next_q.state = ST_IDLE;
                    irq_set[IRQ_MSG] = q.ie;
                    if (is_end(q.tc)) begin
                        // see R13
                        next_q.xst[0] = 16'h0;
                        next_q.xst[1] = 16'h0;
                        next_q.xst[2] = 16'h0;
                        next_q.xst[3] = q.xst[3] & EXTENDED_STATUS_WORD_THREE_KEEP;
                    end
                end else begin
                    next_q.idx = q.idx + 3'h1;
                end
            end
            ST_INIT: begin
                // see R12
                next_q.state = ST_IDLE;
                next_q.resid = 16'h0;
                next_q.xst = '0;
                next_q.retain = 2'h0;
                next_q.diag = 1'b0;
                irq_set[IRQ_INIT] = 1'b1;
            end
            default: begin
            end
        endcase
        if (wr) begin
            case (paddr)
                A_CMD0: next_q.cmd0 = pwdata[15:0];
                A_CTRL: next_q.diag = pwdata[1];
                A_RESID: next_q.resid = pwdata[15:0];
                A_EXTENDED_STATUS_WORD_ZERO: next_q.xst[0] = pwdata[15:0];
                A_EXTENDED_STATUS_WORD_ZERO + 8'h04: next_q.xst[1] = pwdata[15:0];
                A_EXTENDED_STATUS_WORD_ZERO + 8'h08: next_q.xst[2] = pwdata[15:0];
                A_EXTENDED_STATUS_WORD_THREE: next_q.xst[3] = pwdata[15:0];
                A_IRQ_EN: next_q.irq_en = pwdata[2:0];
                A_RETAIN: next_q.retain = pwdata[1:0];
                A_MREQ: begin
                    next_q.state = ST_BUILD;
                    next_q.idx = 3'h0;
                    next_q.tc = pwdata[2:0];
                    next_q.kind = pwdata[MREQ_KIND_BIT];
                    next_q.ie = 1'b1;
                end
                default: begin
                end
            endcase
        end
        if (go_ok) begin
            next_q.ie = q.cmd0[CMD_IE_BIT];
            next_q.idx = 3'h0;
            next_q.kind = 1'b0;
            if (q.cmd0[3:0] != CMD_INIT || q.cmd0[6:4] != FMT_ONE_WORD
                || (q.cmd0 & CMD_MODE_MASK) != 16'h0) begin
                // Foreign code or nonzero mode is an illegal command (see R14) (see R3)
                next_q.state = ST_BUILD;
                next_q.tc = TC_FAIL;
                irq_set[IRQ_REJ] = 1'b1;
            end else if (pwdata[1] | q.diag) begin
                next_q.state = ST_INIT; // see R2
            end else begin
                next_q.state = ST_BUILD; // see R1
                next_q.tc = TC_END;
            end
        end
        // Status word write overrides anything else in flight
        if (ssr_word) begin
            next_q.state = ST_INIT; // see R12
        end
        // Set beats clear when both land together
        next_q.irq_st = (q.irq_st & ~((wr && paddr == A_IRQ_CLR) ? pwdata[2:0] : 3'h0))
                        | irq_set;
        next_q.irq = |(next_q.irq_st & next_q.irq_en);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    tic_msg_store #(.WORDS(MSG_WORDS), .DW(16)) u_store (
        .pclk(pclk),
        .m(m.store)
    );

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign irq = q.irq;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic init_go;
    assign init_go = go_ok && q.cmd0[3:0] == CMD_INIT && q.cmd0[6:4] == 3'h0
                     && (q.cmd0 & CMD_MODE_MASK) == 16'h0;

    a_init_noop: assert property (init_go && !pwdata[1] && !q.diag // see R1
        |=> q.state == ST_BUILD && q.tc == TC_END ##6 q.state == ST_IDLE)
        else $error("Initialize without diag errors did not build an end message");
    a_init_diag: assert property (init_go && (pwdata[1] || q.diag) // see R2
        |=> q.state == ST_INIT ##1 q.resid == 16'h0 && !q.diag)
        else $error("Initialize with diag errors did not reset the subsystem");
    a_mode_reject: assert property (go_ok && (q.cmd0 & CMD_MODE_MASK) != 16'h0 // see R3
        |=> q.state == ST_BUILD && q.tc == TC_FAIL)
        else $error("Nonzero mode field was not rejected");
    // A build in flight may move the state, so only an idle write is judged
    a_word1_ignored: assert property (wr && paddr == A_CMD1 && q.state == ST_IDLE // see R4
        |=> $stable(q.cmd0) && $stable(q.state))
        else $error("Second command word changed state");
    a_ack_end: assert property (m.we && m.waddr == 3'h0 && q.tc != TC_ATTENTION_MESSAGE // see R5
        |-> m.wdata[HDR_ACK_BIT])
        else $error("Buffer-free bit missing on a non-attention message");
    a_ack_attention_message: assert property (m.we && m.waddr == 3'h0 && q.tc == TC_ATTENTION_MESSAGE // see R6
        |-> !m.wdata[HDR_ACK_BIT])
        else $error("Buffer-free bit set on an attention message");
    a_hdr_reserved: assert property (m.we && m.waddr == 3'h0 // see R7 see R9
        |-> m.wdata[14:12] == 3'h0 && m.wdata[7:5] == 3'h0)
        else $error("Reserved or format bits nonzero in header");
    a_hdr_class: assert property (m.we && m.waddr == 3'h0 // see R8
        |-> (q.tc == TC_FAIL) ? (m.wdata[11:8] == (q.kind ? 4'h2 : 4'h1))
            : (m.wdata[11:8] == 4'h0))
        else $error("Wrong class code in header");
    a_msg_code: assert property (m.we && m.waddr == 3'h0 && q.tc[2] // see R10
        |-> m.wdata[4:0] == 5'h12)
        else $error("Error classes did not give the error message code");
    // A status word write legally cuts a packet short
    a_word_order: assert property (disable iff (!presetn || ssr_word) // see R11
        m.we && m.waddr == 3'h0
        |=> m.we && m.waddr == 3'h1 && m.wdata == q.resid
        ##1 m.we && m.waddr == 3'h2 ##1 m.we && m.waddr == 3'h3
        ##1 m.we && m.waddr == 3'h4 ##1 m.we && m.waddr == 3'h5 ##1 !m.we)
        else $error("Packet words out of order");
    a_ssr_halt: assert property (ssr_word // see R12
        |=> q.state == ST_INIT ##1 q.state == ST_IDLE && q.xst == '0 && q.retain == 2'h0)
        else $error("Status word write did not halt and erase");
    a_xst_clear: assert property (m.we && m.waddr == 3'h5 && is_end(q.tc) // see R13
        && !wr && !ssr_word
        |=> q.xst[0] == 16'h0 && (q.xst[3] & ~EXTENDED_STATUS_WORD_THREE_KEEP) == 16'h0)
        else $error("Extended status not cleared after end message");

    c_init_noop: cover property (init_go && !q.diag ##7 q.irq_st[IRQ_MSG]);
    c_init_diag: cover property (init_go && q.diag ##2 q.irq_st[IRQ_INIT]);
    c_attention_message_msg: cover property (m.we && m.waddr == 3'h0 && q.tc == TC_ATTENTION_MESSAGE);
    c_ssr_halt: cover property (ssr_word && q.state == ST_BUILD);
endmodule
`default_nettype wire

// ===== test/tic_host_model.sv
/*
 Host processor side of the register bus: an APB master, one transfer at a time.
 Assumes the bench calls its task right after a rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module tic_host_model (
    input wire logic pclk,
    input wire logic pready,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [tic_pkg::ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb
);
    import tic_pkg::*;
    int timeouts;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
        timeouts = 0;
    end
    // Request is held until pready is seen high at a rising edge, or for at most 100 edges
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) timeouts++;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released address and write data lines do not keep the last value
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ===== test/tic_core_tb_top.sv
/*
 Self-checking bench for the Initialize command and message packet builder.
 Assumes the host model drives the bus; a watcher checks every completion.
*/
`timescale 1ns/100ps
`default_nettype none
module tic_core_tb_top;
    import tic_pkg::*;
    typedef struct packed {logic err; logic rd; logic [31:0] data;} tic_note_type;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    int fails, checks, seed;
    tic_note_type notes[$];
    tic_note_type note;
    logic [31:0] vals[5];

    tic_core #(.WORDS(MSG_WORDS)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    tic_host_model HOST (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

    always #25 pclk = ~pclk;

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: %s is %b expected %b", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
                      input logic e = 1'b0);
        notes.push_back({e, 1'b0, 32'h0});
        HOST.xfer(1'b1, a, d, s);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic e = 1'b0);
        notes.push_back({e, 1'b1, exp});
        HOST.xfer(1'b0, a, 32'h0, 4'h0);
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        chk_flag(irq, 1'b1, "irq");
    endtask
    function automatic logic [31:0] exp_hdr(input logic [2:0] tc, input logic kind);
        logic [3:0] cls;
        logic [4:0] code;
        cls = (tc == 3'h3) ? (kind ? 4'h2 : 4'h1) : 4'h0;
        case (tc)
            3'h0, 3'h2: code = 5'h10;
            3'h1: code = 5'h13;
            3'h3: code = 5'h11;
            default: code = 5'h12;
        endcase
        exp_hdr = {16'h0, tc != 3'h1, 3'h0, cls, 3'h0, code};
    endfunction

    // Each completed transfer retires the oldest expectation
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            if (notes.size() == 0) begin
                fails++;
                $display("MISMATCH at %0t: completion with nothing expected", $time);
            end else begin
                note = notes.pop_front();
                chk_flag(pslverr, note.err, "pslverr");
                if (note.rd && !note.err) chk_data(prdata, note.data);
            end
        end
    end

    task automatic results();
        fails += HOST.timeouts;
        // Expectations never retired mean a transfer never completed
        fails += notes.size();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        results();
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        fails = 0;
        checks = 0;
        seed = 91348;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_IRQ_ST, 32'h0);
        rd(8'h50, 32'h0, 1'b1);
        wr(8'h50, 32'h1, 4'hf, 1'b1);
        wr(A_IRQ_EN, 32'h7);
        for (int tc = 0; tc < 8; tc++) begin
            for (int k = 0; k < 2; k++) begin
                wr(A_MREQ, {27'h0, 1'(k), 1'b0, 3'(tc)});
                wait_irq();
                rd(A_MSG0, exp_hdr(3'(tc), 1'(k)));
                wr(A_IRQ_CLR, 32'h1);
            end
        end
        // Packet layout and end-message clearing of extended status
        for (int i = 0; i < 5; i++) begin
            vals[i] = {16'h0, 16'($random(seed))};
            wr(8'(A_RESID + 4 * i), vals[i]);
        end
        wr(A_MREQ, 32'h0);
        // A second request while the packet is still being built is refused
        wr(A_MREQ, 32'h1, 4'hf, 1'b1);
        wait_irq();
        for (int i = 0; i < 5; i++) rd(8'(A_MSG0 + 4 * (i + 1)), vals[i]);
        for (int i = 0; i < 3; i++) rd(8'(A_EXTENDED_STATUS_WORD_ZERO + 4 * i), 32'h0);
        rd(A_EXTENDED_STATUS_WORD_THREE, vals[4] & {16'h0, EXTENDED_STATUS_WORD_THREE_KEEP});
        wr(A_IRQ_CLR, 32'h7);
        // Masked event stays pending until enabled
        wr(A_IRQ_EN, 32'h0);
        wr(A_MREQ, 32'h1);
        repeat (10) @(posedge pclk);
        chk_flag(irq, 1'b0, "masked irq");
        rd(A_IRQ_ST, 32'h1);
        wr(A_IRQ_EN, 32'h7);
        wait_irq();
        wr(A_IRQ_CLR, 32'h1);
        repeat (3) @(posedge pclk);
        chk_flag(irq, 1'b0, "cleared irq");
        rd(A_IRQ_CLR, 32'h0);
        // Byte write of status register must not initialize
        wr(A_RETAIN, 32'h3);
        wr(A_SSR, 32'h1, 4'h1);
        rd(A_RETAIN, 32'h3);
        // Initialize without pending diagnostics: no reset of retained state
        wr(A_CMD0, 32'h0f8b);
        rd(A_CMD0, 32'h008b);
        wr(A_CMD1, $random(seed));
        rd(A_CMD1, 32'h0);
        wr(A_CMD0, 32'h008b);
        wr(A_IRQ_EN, 32'h1);
        wr(A_CTRL, 32'h1);
        wait_irq();
        rd(A_RETAIN, 32'h3);
        rd(A_MSG0, exp_hdr(3'h0, 1'b0));
        rd(A_IRQ_ST, 32'h1);
        wr(A_IRQ_CLR, 32'h7);
        // Wrong command code is rejected
        wr(A_CMD0, 32'h0089);
        wr(A_IRQ_EN, 32'h4);
        wr(A_CTRL, 32'h1);
        wait_irq();
        wr(A_IRQ_CLR, 32'h7);
        // Nonzero mode field is rejected as an illegal command
        wr(A_CMD0, 32'h018b);
        wr(A_CTRL, 32'h1);
        wait_irq();
        rd(A_MSG0, exp_hdr(3'h3, 1'b0));
        repeat (8) @(posedge pclk);
        wr(A_IRQ_CLR, 32'h7);
        // Word write to status register erases retained state, even mid-packet
        wr(A_MREQ, 32'h0);
        wr(A_SSR, 32'h0, 4'hf);
        rd(A_RETAIN, 32'h0);
        // Initialize with pending diagnostics acts as that word write
        wr(A_RETAIN, 32'h3);
        wr(A_CMD0, 32'h008b);
        wr(A_CTRL, 32'h3);
        repeat (5) @(posedge pclk);
        rd(A_RETAIN, 32'h0);
        // Diagnostic errors flagged earlier through the control register
        wr(A_RETAIN, 32'h3);
        wr(A_CTRL, 32'h2);
        wr(A_CTRL, 32'h1);
        repeat (5) @(posedge pclk);
        rd(A_RETAIN, 32'h0);
        repeat (3) @(posedge pclk);
        results();
    end
endmodule
`default_nettype wire
